//--- rtl/fbrs_fifo.sv
// First-word-fall-through FIFO between array fetch and burst output.
// Assumes one clock; flush wins over a push or pop in the same cycle.
`timescale 1ns/10ps
`default_nettype none
module fbrs_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16,
    parameter int LVL_W = 5
) (
    input wire logic i_clk, // System clock
    input wire logic i_reset_n, // Synchronous reset, active low
    input wire logic i_flush, // Drop all contents
    input wire logic i_s_valid, // Write side valid
    output logic o_s_ready, // Write side ready
    input wire logic [WIDTH-1:0] i_s_data, // Write data
    output logic o_m_valid, // Read side valid
    input wire logic i_m_ready, // Read side ready
    output logic [WIDTH-1:0] o_m_data, // Read data
    output logic [LVL_W-1:0] o_level // Words held
);
    localparam int PTR_W = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0] wr;
        logic [PTR_W-1:0] rd;
        logic [LVL_W-1:0] level;
    } fbrs_fifo_st_t;

    fbrs_fifo_st_t r;
    fbrs_fifo_st_t next_r;
    logic push;
    logic pop;

    assign o_s_ready = (r.level != LVL_W'(DEPTH));
    assign o_m_valid = (r.level != '0);
    assign o_m_data = r.mem[r.rd];
    assign o_level = r.level;
    assign push = i_s_valid && o_s_ready;
    assign pop = i_m_ready && o_m_valid;

    always_comb
    begin
        next_r = r;
        if (i_flush)
        begin
            next_r.wr = '0;
            next_r.rd = '0;
            next_r.level = '0;
        end
        else
        begin
            if (push)
            begin
                next_r.mem[r.wr] = i_s_data;
                next_r.wr = r.wr + 1'b1;
            end
            if (pop)
            begin
                next_r.rd = r.rd + 1'b1;
            end
            if (push && !pop)
            begin
                next_r.level = r.level + 1'b1;
            end
            else if (pop && !push)
            begin
                next_r.level = r.level - 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

endmodule
`default_nettype wire

//--- rtl/fbrs_pkg.sv
// Sequencer package: widths, configuration layout, states.
// Assumes the word-wide array and the command decoder live elsewhere.
package fbrs_pkg;

    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int ADDR_W = 25;
    localparam int DATA_W = 16;
    localparam int FIFO_DEPTH = 16;
    localparam int LEVEL_W = 5;
    localparam int LEFT_W = 6;
    localparam int LAT_W = 4;
    localparam int NUM_BANKS = 16;
    localparam int BANK_LSB = 21;
    localparam int BANK_MSB = 24;
    localparam int LINE_MSB = 6;

    // ----------------------------------------
    // Configuration layout
    // ----------------------------------------
    localparam logic [15:0] CR0_RESET = 16'hef00;
    localparam logic [15:0] CR1_RESET = 16'h0001;
    localparam int CR0_MODE_BIT = 15;
    localparam int CR0_WS_MSB = 13;
    localparam int CR0_WS_LSB = 11;
    localparam int CR0_RDY_POL_BIT = 10;
    localparam int CR0_RDY_LATE_BIT = 8;
    localparam int CR0_WRAP_BIT = 3;
    localparam int CR0_LEN_MSB = 2;
    localparam int CR0_LEN_LSB = 0;
    localparam int CR1_WS_HI_BIT = 0;

    localparam logic [2:0] LEN_8 = 3'h2;
    localparam logic [2:0] LEN_16 = 3'h3;
    localparam logic [2:0] LEN_32 = 3'h4;

    localparam logic [ADDR_W-1:0] MASK_8 = 25'h000_0007;
    localparam logic [ADDR_W-1:0] MASK_16 = 25'h000_000f;
    localparam logic [ADDR_W-1:0] MASK_32 = 25'h000_001f;
    localparam logic [LEFT_W-1:0] WORDS_8 = 6'h08;
    localparam logic [LEFT_W-1:0] WORDS_16 = 6'h10;
    localparam logic [LEFT_W-1:0] WORDS_32 = 6'h20;
    localparam logic [LEFT_W-1:0] ONE_LEFT = 6'h01;
    localparam logic [LINE_MSB:0] LINE_START = 7'h00;

    // Rising edges from address latch to initial data
    localparam logic [LAT_W-1:0] EDGES_BASE = 4'h2;
    localparam logic [LAT_W-1:0] EDGES_HIGH = 4'h8;
    localparam logic [LAT_W-1:0] EDGES_MAX = 4'hb;
    localparam logic [LAT_W-1:0] LAT_ONE = 4'h1;
    localparam logic [LAT_W-1:0] LAT_TWO = 4'h2;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        FBRS_IDLE,
        FBRS_STREAM,
        FBRS_STATUS
    } fbrs_state_t;

    // Reserved and default codes take the longest
    function automatic logic [LAT_W-1:0] wait_edges(input logic [3:0] code);
        logic [LAT_W-1:0] e;
        e = EDGES_MAX;
        if (code <= 4'h5)
        begin
            e = EDGES_BASE + code;
        end
        else if (code >= 4'h8 && code <= 4'hb)
        begin
            e = EDGES_HIGH + {2'h0, code[1:0]};
        end
        return e;
    endfunction

endpackage

//--- rtl/fbrs_sequencer.sv
// Burst read sequencer and read-mode configuration of a 16-bit flash.
// Assumes host inputs synchronous to i_clk and an array answering in-cycle.
// Functional notes
// - Continuous burst gives ascending words, top wraps to zero.
// - Continuous burst runs until chip enable high or reset.
// - New address strobe aborts any burst, restarts there.
// - Line crossing within a bank adds one wait cycle.
// - Crossing into a busy bank shows status, ignores clocks.
// - Linear bursts read 8, 16 or 32 words; wrapping ones stay in one group.
// - Wrap runs to group end, resumes at group start, stops.
// - Wrapping bursts add no line wait cycles.
// - Non-wrap linear bursts ascend from start, then stop.
// - Non-wrap line crossing adds the extra wait cycle.
// - Two 16-bit configuration registers.
// - Reset restores asynchronous mode and defaults.
// - Configuration read returns register contents.
// - Low bit 15 clear enables bursts; set, default, asynchronous.
// - Low bit 14 reserved, unused, default one.
// - Four-bit wait code picks the initial data edge.
// - Bit 10 sets ready polarity, default active high.
// - Bit 8 clear: ready a clock early; set: with data.
`timescale 1ns/10ps
`default_nettype none
module fbrs_sequencer (
    input wire logic i_clk, // Burst clock, 50 MHz
    input wire logic i_reset_n, // Synchronous reset, active low
    input wire logic i_chip_enable_n, // Chip enable, active low
    input wire logic i_address_valid_strobe_n, // Address latch strobe, active low
    input wire logic [fbrs_pkg::ADDR_W-1:0] i_addr, // Word address
    input wire logic [fbrs_pkg::NUM_BANKS-1:0] i_bank_busy, // Bank programming or erasing
    input wire logic [fbrs_pkg::DATA_W-1:0] i_status_word, // Read status of busy bank
    input wire logic [fbrs_pkg::DATA_W-1:0] i_array_data, // Array word for o_array_addr
    output logic [fbrs_pkg::ADDR_W-1:0] o_array_addr, // Array fetch address
    output logic o_array_read, // Array fetch strobe
    input wire logic i_cfg_write, // Set configuration strobe
    input wire logic i_cfg_read, // Read configuration strobe
    input wire logic i_cfg_select, // 0 low register, 1 high register
    input wire logic [15:0] i_cfg_wdata, // Configuration write data
    output logic [15:0] o_cfg_rdata, // Configuration read data
    output logic [fbrs_pkg::DATA_W-1:0] o_data, // Burst data out
    output logic o_ready, // Ready, polarity per configuration
    output logic o_status_active, // Status word being shown
    output logic o_burst_active // Burst in progress
);
    localparam int AW = fbrs_pkg::ADDR_W;

    typedef struct packed {
        fbrs_pkg::fbrs_state_t state;
        logic [15:0] cr0;
        logic [15:0] cr1;
        logic [AW-1:0] start_addr;
        logic [AW-1:0] fetch_addr;
        logic [AW-1:0] out_addr;
        logic [fbrs_pkg::LEFT_W-1:0] fetch_left;
        logic [fbrs_pkg::LEFT_W-1:0] out_left;
        logic fetch_on;
        logic [fbrs_pkg::LAT_W-1:0] lat_cnt;
        logic line_waited;
        logic first_word;
        logic popped;
        logic [fbrs_pkg::DATA_W-1:0] word_a;
        logic [AW-1:0] array_addr;
        logic array_read;
        logic [fbrs_pkg::DATA_W-1:0] data;
        logic ready;
        logic status;
        logic active;
        logic [15:0] cfg_rdata;
    } fbrs_seq_st_t;

    fbrs_seq_st_t r;
    fbrs_seq_st_t next_r;

    // ----------------------------------------
    // Address helpers
    // ----------------------------------------
    function automatic logic [AW-1:0] group_mask(input logic [2:0] len);
        logic [AW-1:0] m;
        m = '0;
        if (len == fbrs_pkg::LEN_8)
        begin
            m = fbrs_pkg::MASK_8;
        end
        else if (len == fbrs_pkg::LEN_16)
        begin
            m = fbrs_pkg::MASK_16;
        end
        else if (len == fbrs_pkg::LEN_32)
        begin
            m = fbrs_pkg::MASK_32;
        end
        return m;
    endfunction

    // Wrap holds the upper bits; plain step rolls top to zero
    function automatic logic [AW-1:0] step_addr(input logic [AW-1:0] a,
                                                 input logic wrap,
                                                 input logic [AW-1:0] mask);
        logic [AW-1:0] inc;
        inc = a + 1'b1;
        if (wrap)
        begin
            step_addr = (a & ~mask) | (inc & mask);
        end
        else
        begin
            step_addr = inc;
        end
    endfunction

    function automatic logic busy_cross(input logic [AW-1:0] a, input logic [AW-1:0] s,
                                        input logic [fbrs_pkg::NUM_BANKS-1:0] busy);
        logic [3:0] b;
        b = a[fbrs_pkg::BANK_MSB:fbrs_pkg::BANK_LSB];
        return (b != s[fbrs_pkg::BANK_MSB:fbrs_pkg::BANK_LSB]) && busy[b];
    endfunction

    // ----------------------------------------
    // Configuration decode
    // ----------------------------------------
    logic sync_mode;
    logic rdy_high;
    logic rdy_late;
    logic [2:0] len;
    logic linear;
    logic wrap;
    logic [AW-1:0] mask;
    logic [fbrs_pkg::LEFT_W-1:0] words;
    logic [fbrs_pkg::LAT_W-1:0] edges;

    always_comb
    begin
        sync_mode = !r.cr0[fbrs_pkg::CR0_MODE_BIT];
        rdy_high = r.cr0[fbrs_pkg::CR0_RDY_POL_BIT];
        rdy_late = r.cr0[fbrs_pkg::CR0_RDY_LATE_BIT];
        len = r.cr0[fbrs_pkg::CR0_LEN_MSB:fbrs_pkg::CR0_LEN_LSB];
        mask = group_mask(len);
        linear = (mask != '0);
        wrap = linear && r.cr0[fbrs_pkg::CR0_WRAP_BIT];
        words = fbrs_pkg::LEFT_W'(mask) + 1'b1;
        edges = fbrs_pkg::wait_edges({r.cr1[fbrs_pkg::CR1_WS_HI_BIT],
                                      r.cr0[fbrs_pkg::CR0_WS_MSB:fbrs_pkg::CR0_WS_LSB]});
    end

    // ----------------------------------------
    // Word buffer
    // ----------------------------------------
    logic fifo_flush;
    logic fifo_s_ready;
    logic fifo_m_valid;
    logic fifo_pop;
    logic [fbrs_pkg::DATA_W-1:0] fifo_data;
    logic [fbrs_pkg::LEVEL_W-1:0] fifo_level;

    fbrs_fifo #(
        .WIDTH(fbrs_pkg::DATA_W),
        .DEPTH(fbrs_pkg::FIFO_DEPTH),
        .LVL_W(fbrs_pkg::LEVEL_W)
    ) u_fifo (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_flush(fifo_flush),
        .i_s_valid(fifo_push),
        .o_s_ready(fifo_s_ready),
        .i_s_data(i_array_data),
        .o_m_valid(fifo_m_valid),
        .i_m_ready(fifo_pop),
        .o_m_data(fifo_data),
        .o_level(fifo_level)
    );

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    logic start;
    logic room;
    logic line_hold;
    logic out_busy;
    logic avail;
    logic take;
    logic fifo_push;
    logic [fbrs_pkg::DATA_W-1:0] out_word;

    always_comb
    begin
        next_r = r;
        start = !i_chip_enable_n && !i_address_valid_strobe_n && sync_mode;
        fifo_flush = start || i_chip_enable_n;
        // Count the fetch still in flight so a full buffer never drops a word
        room = fifo_s_ready
            && ({1'b0, fifo_level} + {5'h00, r.array_read} < 6'(fbrs_pkg::FIFO_DEPTH));
        line_hold = !wrap && !r.first_word && !r.line_waited
            && (r.out_addr[fbrs_pkg::LINE_MSB:0] == fbrs_pkg::LINE_START);
        out_busy = busy_cross(r.out_addr, r.start_addr, i_bank_busy);
        // Empty buffer is bypassed so data can meet the second edge
        avail = fifo_m_valid || r.array_read;
        out_word = fifo_m_valid ? fifo_data : i_array_data;
        take = (r.state == fbrs_pkg::FBRS_STREAM) && (r.lat_cnt == '0)
            && avail && !line_hold && !out_busy && !fifo_flush;
        fifo_pop = take && fifo_m_valid;
        fifo_push = r.array_read && !(take && !fifo_m_valid);

        // Fetch side
        next_r.array_read = 1'b0;
        if (r.state == fbrs_pkg::FBRS_STREAM && r.fetch_on && room)
        begin
            if (busy_cross(r.fetch_addr, r.start_addr, i_bank_busy))
            begin
                next_r.fetch_on = 1'b0;
            end
            else
            begin
                next_r.array_read = 1'b1;
                next_r.array_addr = r.fetch_addr;
                next_r.fetch_addr = step_addr(r.fetch_addr, wrap, mask);
                if (linear)
                begin
                    next_r.fetch_left = r.fetch_left - 1'b1;
                    next_r.fetch_on = (r.fetch_left != fbrs_pkg::ONE_LEFT);
                end
            end
        end

        // Output side
        if (r.state == fbrs_pkg::FBRS_STREAM)
        begin
            if (r.lat_cnt != '0)
            begin
                next_r.lat_cnt = r.lat_cnt - 1'b1;
            end
            else if (out_busy)
            begin
                next_r.state = fbrs_pkg::FBRS_STATUS;
            end
            else if (line_hold && avail)
            begin
                next_r.line_waited = 1'b1;
            end
            else if (take)
            begin
                next_r.out_addr = step_addr(r.out_addr, wrap, mask);
                next_r.first_word = 1'b0;
                next_r.line_waited = 1'b0;
                if (linear)
                begin
                    next_r.out_left = r.out_left - 1'b1;
                    if (r.out_left == fbrs_pkg::ONE_LEFT)
                    begin
                        next_r.state = fbrs_pkg::FBRS_IDLE;
                    end
                end
            end
        end

        next_r.popped = take;
        next_r.word_a = take ? out_word : r.word_a;
        // Early ready: data trails the ready strobe by one clock
        if (rdy_late && take)
        begin
            next_r.data = out_word;
        end
        else if (!rdy_late && r.popped)
        begin
            next_r.data = r.word_a;
        end
        if (r.state == fbrs_pkg::FBRS_STATUS)
        begin
            next_r.data = i_status_word;
        end
        next_r.ready = rdy_high ? take : !take;

        // Start, abort and deselect
        if (i_chip_enable_n)
        begin
            next_r.state = fbrs_pkg::FBRS_IDLE;
            next_r.array_read = 1'b0;
        end
        else if (start)
        begin
            next_r.state = fbrs_pkg::FBRS_STREAM;
            next_r.start_addr = i_addr;
            next_r.array_addr = i_addr;
            next_r.fetch_addr = step_addr(i_addr, wrap, mask);
            next_r.out_addr = i_addr;
            next_r.fetch_left = words - 1'b1;
            next_r.out_left = words;
            next_r.fetch_on = 1'b1;
            next_r.first_word = 1'b1;
            next_r.line_waited = 1'b0;
            next_r.array_read = 1'b1;
            next_r.popped = 1'b0;
            // First fetch leaves with the latch, so ready can meet edge two
            if (!rdy_late)
            begin
                next_r.lat_cnt = (edges > fbrs_pkg::LAT_TWO + fbrs_pkg::LAT_ONE)
                    ? edges - fbrs_pkg::LAT_TWO - fbrs_pkg::LAT_ONE : '0;
            end
            else
            begin
                next_r.lat_cnt = edges - fbrs_pkg::LAT_TWO;
            end
        end
        next_r.status = (next_r.state == fbrs_pkg::FBRS_STATUS);
        next_r.active = (next_r.state != fbrs_pkg::FBRS_IDLE);

        // Configuration access
        if (i_cfg_write)
        begin
            if (i_cfg_select)
            begin
                next_r.cr1 = i_cfg_wdata;
            end
            else
            begin
                next_r.cr0 = i_cfg_wdata;
            end
        end
        if (i_cfg_read)
        begin
            next_r.cfg_rdata = i_cfg_select ? r.cr1 : r.cr0;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            r <= '0;
            r.state <= fbrs_pkg::FBRS_IDLE;
            r.cr0 <= fbrs_pkg::CR0_RESET;
            r.cr1 <= fbrs_pkg::CR1_RESET;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign o_array_addr = r.array_addr;
    assign o_array_read = r.array_read;
    assign o_cfg_rdata = r.cfg_rdata;
    assign o_data = r.data;
    assign o_ready = r.ready;
    assign o_status_active = r.status;
    assign o_burst_active = r.active;

endmodule
`default_nettype wire

//--- testbench/fbrs_host_model.sv
// Host model: chip enable, address strobe, start address.
// Assumes tasks are called from the i_clk domain.
`timescale 1ns/10ps
`default_nettype none
module fbrs_host_model (
    input wire logic i_clk, // Burst clock
    output logic o_chip_enable_n, // Chip enable, active low
    output logic o_address_valid_strobe_n, // Address strobe, active low
    output logic [fbrs_pkg::ADDR_W-1:0] o_addr // Word address
);
    initial
    begin
        o_chip_enable_n = 1'b1;
        o_address_valid_strobe_n = 1'b1;
        o_addr = '0;
    end

    // One strobe pulse with a new address; also aborts a running burst
    task automatic launch(input logic [fbrs_pkg::ADDR_W-1:0] a);
        @(posedge i_clk) #1;
        o_chip_enable_n = 1'b0;
        o_address_valid_strobe_n = 1'b0;
        o_addr = a;
        @(posedge i_clk) #1;
        o_address_valid_strobe_n = 1'b1;
        o_addr = ~a;
    endtask

    task automatic stop();
        @(posedge i_clk) #1;
        o_chip_enable_n = 1'b1;
    endtask
endmodule
`default_nettype wire

//--- testbench/fbrs_sequencer_checker.sv
// Port-level assertions for the burst sequencer.
// Assumes it is bound to fbrs_sequencer and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module fbrs_sequencer_checker (
    input wire logic i_clk, // Clock
    input wire logic i_reset_n, // Reset
    input wire logic i_chip_enable_n, // Chip enable
    input wire logic i_address_valid_strobe_n, // Strobe
    input wire logic [fbrs_pkg::ADDR_W-1:0] i_addr, // Start address
    input wire logic i_cfg_write, // Config write
    input wire logic i_cfg_read, // Config read
    input wire logic i_cfg_select, // Register select
    input wire logic [15:0] i_cfg_wdata, // Config data
    input wire logic [fbrs_pkg::ADDR_W-1:0] o_array_addr, // Fetch address
    input wire logic o_array_read, // Fetch strobe
    input wire logic [15:0] o_cfg_rdata, // Config read data
    input wire logic o_ready, // Ready
    input wire logic o_status_active, // Status shown
    input wire logic o_burst_active // Burst running
);
    // ----------------------------------------
    // Shadow of the configuration
    // ----------------------------------------
    logic [15:0] cfg0;
    logic [15:0] cfg1;
    logic [5:0] fetches;
    logic [5:0] words;
    logic [fbrs_pkg::ADDR_W-1:0] m;
    logic take;
    assign take = !i_chip_enable_n && !i_address_valid_strobe_n && !cfg0[15];
    assign words = cfg0[2:0] == fbrs_pkg::LEN_8 ? fbrs_pkg::WORDS_8 :
        cfg0[2:0] == fbrs_pkg::LEN_16 ? fbrs_pkg::WORDS_16 :
        cfg0[2:0] == fbrs_pkg::LEN_32 ? fbrs_pkg::WORDS_32 : 6'h00;
    assign m = cfg0[3] && words != 6'h00 ? 25'(words - 6'h01) : '0;

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            cfg0 <= fbrs_pkg::CR0_RESET;
            cfg1 <= fbrs_pkg::CR1_RESET;
            fetches <= 6'h00;
        end
        else
        begin
            if (i_cfg_write && !i_cfg_select)
                cfg0 <= i_cfg_wdata;
            if (i_cfg_write && i_cfg_select)
                cfg1 <= i_cfg_wdata;
            fetches <= take ? 6'h00 : fetches + {5'h00, o_array_read};
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);

    a_reset_idle: assert property (disable iff (1'b0) !i_reset_n |=>
        !o_burst_active && !o_status_active && !o_ready && !o_array_read && o_cfg_rdata == 16'h0000)
        else $error("not idle after reset");
    a_async_ignored: assert property (!i_chip_enable_n && !i_address_valid_strobe_n &&
        cfg0[15] && !o_burst_active |=> !o_burst_active)
        else $error("burst in async mode");
    a_strobe_starts: assert property (take |=>
        o_burst_active && o_array_read && o_array_addr == $past(i_addr))
        else $error("wrong first fetch");
    a_ce_stops: assert property (i_chip_enable_n |=> !o_burst_active && !o_array_read)
        else $error("burst with chip enable high");
    a_cfg_readback: assert property (i_cfg_read |=>
        o_cfg_rdata == ($past(i_cfg_select) ? $past(cfg1) : $past(cfg0)))
        else $error("config readback wrong");
    a_fetch_step: assert property (o_array_read && $past(o_array_read) &&
        $past(i_address_valid_strobe_n) |-> o_array_addr == (m == '0 ?
        $past(o_array_addr) + 25'h1 :
        ($past(o_array_addr) & ~m) | (($past(o_array_addr) + 25'h1) & m)))
        else $error("fetch out of sequence");
    a_fetch_limit: assert property (o_array_read && words != 6'h00 |-> fetches < words)
        else $error("too many fetches");
    a_first_ready: assert property (take && {cfg1[0], cfg0[13:11]} == 4'h0 && cfg0[8] |=>
        o_ready != cfg0[10] ##1 o_ready == cfg0[10])
        else $error("first ready late");
    a_status_quiet: assert property (o_status_active |-> o_ready != cfg0[10] && o_burst_active)
        else $error("ready during status");
endmodule
bind fbrs_sequencer fbrs_sequencer_checker i_chk (.*);
`default_nettype wire

//--- testbench/fbrs_sequencer_test.sv
// Self-checking bench for the burst sequencer with a host model.
// Assumes the array answers combinationally from o_array_addr.
`timescale 1ns/10ps
`default_nettype none
`define CHK(x, e) begin check_count++; if ((x) !== (e)) begin num_errors++; \
    $display("BAD %0t got %0h want %0h", $time, x, e); end end
module fbrs_sequencer_test;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic ce_n, avs_n, cw = 1'b0, cr = 1'b0, cs = 1'b0;
    logic ready, stat, busy;
    logic [24:0] addr, arr_addr, a;
    logic [15:0] bank_busy = '0, sw = '0, cwd = '0, crd, data, arr_data, cfg0;
    logic [3:0] code;
    logic [2:0] lens [5] = '{3'h2, 3'h3, 3'h4, 3'h0, 3'h7};
    int num_errors = 0;
    int check_count = 0;
    int r;

    always #10 i_clk = ~i_clk;
    assign arr_data = word_of(arr_addr);

    fbrs_host_model i_host (
        .i_clk(i_clk),
        .o_chip_enable_n(ce_n),
        .o_address_valid_strobe_n(avs_n),
        .o_addr(addr)
    );
    fbrs_sequencer i_dut (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_chip_enable_n(ce_n),
        .i_address_valid_strobe_n(avs_n),
        .i_addr(addr),
        .i_bank_busy(bank_busy),
        .i_status_word(sw),
        .i_array_data(arr_data),
        .o_array_addr(arr_addr),
        .o_array_read(),
        .i_cfg_write(cw),
        .i_cfg_read(cr),
        .i_cfg_select(cs),
        .i_cfg_wdata(cwd),
        .o_cfg_rdata(crd),
        .o_data(data),
        .o_ready(ready),
        .o_status_active(stat),
        .o_burst_active(busy)
    );

    // ----------------------------------------
    // Expectations
    // ----------------------------------------
    function automatic logic [15:0] word_of(input logic [24:0] w);
        return w[15:0] ^ {w[24:21], 12'h5a3};
    endfunction

    function automatic int words(input logic [15:0] c);
        return c[2:0] == 3'h2 ? 8 : c[2:0] == 3'h3 ? 16 : c[2:0] == 3'h4 ? 32 : 0;
    endfunction

    function automatic logic [24:0] step(input logic [24:0] w, input logic [15:0] c);
        logic [24:0] m;
        m = 25'(words(c) - 1);
        if (!c[3] || words(c) == 0)
            return w + 25'h1;
        return (w & ~m) | ((w + 25'h1) & m);
    endfunction

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic conclude();
        if (num_errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic cfg_io(input logic wr, input logic sel, input logic [15:0] v);
        @(posedge i_clk) #1;
        cw = wr;
        cr = !wr;
        cs = sel;
        cwd = v;
        @(posedge i_clk) #1;
        cw = 1'b0;
        cr = 1'b0;
        if (!wr)
            `CHK(crd, v);
    endtask

    // Reserved bits kept at one
    task automatic setup(input logic [3:0] c, input logic [2:0] len, input logic wrap);
        code = c;
        cfg0 = {2'b01, c[2:0], 1'($urandom_range(1)), 1'b1, 1'($urandom_range(1)), 4'h0, wrap, len};
        cfg_io(1'b1, 1'b0, cfg0);
        cfg_io(1'b1, 1'b1, {15'h0000, c[3]});
        cfg_io(1'b0, 1'b0, cfg0);
    endtask

    task automatic burst(input logic [24:0] s, input int n);
        int k, got, last, lat, tgt;
        logic pend;
        logic [24:0] q, qq;
        tgt = n > 0 ? n : 40;
        lat = code <= 4'h5 ? int'(code) + 2 : (code == 4'hd ? 11 : int'(code));
        if (!cfg0[8])
            lat = lat > 2 ? lat - 1 : 2;
        q = s;
        qq = s;
        got = 0;
        last = 0;
        pend = 1'b0;
        i_host.launch(s);
        for (k = 1; k < 300 && got < tgt; k++)
        begin
            if (pend)
                `CHK(data, word_of(qq));
            pend = 1'b0;
            if (ready === cfg0[10])
            begin
                `CHK(k - last, got == 0 ? lat : 1 + int'(!(cfg0[3] && n > 0) && q[6:0] == 7'h00));
                if (cfg0[8])
                    `CHK(data, word_of(q));
                qq = q;
                pend = !cfg0[8];
                q = step(q, cfg0);
                last = k;
                got++;
            end
            @(posedge i_clk) #1;
        end
        if (got < tgt)
        begin
            num_errors++;
            $display("BAD %0t burst timed out", $time);
            conclude();
        end
        if (pend)
            `CHK(data, word_of(qq));
        if (n > 0)
        begin
            repeat (3)
            begin
                `CHK(ready, ~cfg0[10]);
                @(posedge i_clk) #1;
            end
            `CHK(busy, words(cfg0) == 0);
        end
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        void'($urandom(15967));
        repeat (5) @(posedge i_clk) #1;
        i_reset_n = 1'b1;
        cfg_io(1'b0, 1'b0, 16'hef00);
        cfg_io(1'b0, 1'b1, 16'h0001);
        i_host.launch(25'h000_0040);
        repeat (3) @(posedge i_clk) #1;
        `CHK(busy, 1'b0);
        i_host.stop();
        for (r = 0; r < 12; r++)
        begin
            code = 4'($urandom_range(10));
            code = code > 4'h5 ? (code == 4'ha ? 4'hd : code + 4'h2) : code;
            setup(code, lens[r % 5], r / 5 == 1);
            a = 25'($urandom);
            a[6:4] = 3'h7;
            if (r == 3)
                a = 25'h1ff_fff8;
            burst(a, words(cfg0));
            if (words(cfg0) == 0)
            begin
                burst(a ^ 25'h0a5_5555, 0);
                i_host.stop();
            end
        end
        setup(4'h0, 3'h0, 1'b0);
        cfg0[8] = 1'b1;
        cfg_io(1'b1, 1'b0, cfg0);
        bank_busy = 16'h0002;
        sw = 16'($urandom);
        burst(25'h01f_fffc, 4);
        for (r = 0; r < 20 && stat !== 1'b1; r++)
        begin
            @(posedge i_clk) #1;
        end
        repeat (4)
        begin
            `CHK(stat, 1'b1);
            `CHK(data, sw);
            `CHK(ready, ~cfg0[10]);
            @(posedge i_clk) #1;
        end
        bank_busy = 16'h0008;
        burst(25'h05f_fffc, 4);
        i_host.stop();
        i_host.launch(25'h000_0100);
        i_reset_n = 1'b0;
        repeat (2) @(posedge i_clk) #1;
        i_reset_n = 1'b1;
        `CHK(busy, 1'b0);
        cfg_io(1'b0, 1'b0, 16'hef00);
        conclude();
    end
endmodule
`default_nettype wire
